// ---- rtl/output_channel_config_regs.sv ----
// Register bank and datapath for output 1, the pair 0/1 divider and output 2.
`timescale 1ns/1ns
module output_channel_config_regs
    import outcfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Clock sources from pins
    input wire logic synth1In,
    input wire logic synth2In,
    input wire logic pair01SrcIn,
    // Pair 0/1 divided clock, channel 0 copy
    output logic ch0Clk,
    output logic pair01MuxEn,
    // Pair 2/3 selected source
    output logic pair23Clk,
    // Driver pins and settings: bit 0 output 1, bit 1 output 2
    output logic [1:0] drvPos,
    output logic [1:0] drvPosOe,
    output logic [1:0] drvNeg,
    output logic [1:0] drvNegOe,
    output logic [1:0] drvDiffEn,
    output logic [9:0] drvTailMa,
    output logic [15:0] drvLoadOhm
);
    // Register storage
    logic [7:0] outCtl1_reg;
    logic [7:0] outCtl2_reg;
    logic [7:0] div01_reg;
    logic [7:0] pwrDn_reg;
    // Write channel state
    logic awHeld_reg;
    logic wHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [7:0] wByte_reg;
    logic wLane0_reg;
    logic doWrite;
    logic wrHit;
    logic [9:0] wrFull;
    // Read mux
    logic [7:0] readByte;
    logic readHit;
    // Pin synchronisers
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    logic pair01Prev_reg;
    logic pair01Tick;
    logic divTick;
    logic pd01;
    logic pair23Src;

    // Write strobe, powerdown bit and word-aligned write address
    assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
    assign pd01 = pwrDn_reg[PD01_BIT];
    assign wrFull = {2'b00, awAddr_reg[ADDR_W-1:2], 2'b00};

    // Byte address decode shared by both channels
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        logic [9:0] full;
        full = {2'b00, a[ADDR_W-1:2], 2'b00};
        if (full == ADR_PWRDN) begin
            decode = 2'd1;
        end else if (full == ADR_OUT1 || full == ADR_DIV01 || full == ADR_OUT2) begin
            decode = 2'd1;
        end else if (full == ADR_STATUS) begin
            decode = 2'd2;
        end else begin
            decode = 2'd0;
        end
    endfunction

    // Unmapped write addresses get a slave error
    assign wrHit = (decode(awAddr_reg) != 2'd0);

    // Write address acceptance; held until the response is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            awready <= 1'b1;
            awAddr_reg <= '0;
        end else if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awready <= 1'b0;
            awAddr_reg <= awaddr;
        end else if (bvalid && bready) begin
            awHeld_reg <= 1'b0;
            awready <= 1'b1;
        end
    end

    // Write data acceptance, low byte lane only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld_reg <= 1'b0;
            wready <= 1'b1;
            wByte_reg <= 8'h00;
            wLane0_reg <= 1'b0;
        end else if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wready <= 1'b0;
            wByte_reg <= wdata[7:0];
            wLane0_reg <= wstrb[0];
        end else if (bvalid && bready) begin
            wHeld_reg <= 1'b0;
            wready <= 1'b1;
        end
    end

    // Write response once both halves are in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Register updates; reserved bits are masked off and stay zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outCtl1_reg <= RST_OUT1; // R1
            outCtl2_reg <= RST_OUT2; // R2 R8
            div01_reg <= RST_DIV01; // R6
            pwrDn_reg <= RST_PWRDN;
        end else if (doWrite && wLane0_reg) begin
            if (wrFull == ADR_OUT1) begin
                outCtl1_reg <= wByte_reg & MSK_OUT1; // R10
            end else if (wrFull == ADR_DIV01) begin
                div01_reg <= wByte_reg & MSK_DIV01; // R7
            end else if (wrFull == ADR_OUT2) begin
                outCtl2_reg <= wByte_reg & MSK_OUT2; // R10
            end else if (wrFull == ADR_PWRDN) begin
                pwrDn_reg <= wByte_reg & MSK_PWRDN; // R10
            end
        end
    end

    // Read data selection
    always_comb begin
        logic [9:0] full;
        full = {2'b00, araddr[ADDR_W-1:2], 2'b00};
        readHit = (decode(araddr) != 2'd0);
        if (full == ADR_OUT1) begin
            readByte = outCtl1_reg;
        end else if (full == ADR_DIV01) begin
            readByte = div01_reg;
        end else if (full == ADR_OUT2) begin
            readByte = outCtl2_reg;
        end else if (full == ADR_PWRDN) begin
            readByte = pwrDn_reg;
        end else if (full == ADR_STATUS) begin
            readByte = {5'b00000, ch0Clk, pair23Clk, pair01MuxEn};
        end else begin
            readByte = 8'h00;
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, readByte}; // R10
            rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Two-stage synchronisers for the clock source pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg <= 3'b000;
            syncB_reg <= 3'b000;
        end else begin
            syncA_reg <= {pair01SrcIn, synth2In, synth1In};
            syncB_reg <= syncA_reg;
        end
    end

    // Rising-edge detect on the synchronised pair 0/1 source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pair01Prev_reg <= 1'b0;
        end else begin
            pair01Prev_reg <= syncB_reg[2];
        end
    end

    // Source mux is gated off while the pair is powered down
    assign pair01Tick = syncB_reg[2] && !pair01Prev_reg && !pd01; // R9
    assign pair23Src = outCtl2_reg[SRC_BIT] ? syncB_reg[1] : syncB_reg[0]; // R8

    // Single divider shared by channels 0 and 1
    pair_divider #(
        .DIV_W(8)
    ) u_div01 (
        .clk(clk),
        .rst_n(rst_n),
        .enable(!pd01), // R9
        .ratioM1(div01_reg), // R6
        .srcTick(pair01Tick),
        .divTick(divTick) // R7
    );

    // Channel 0 copy of the divided clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch0Clk <= 1'b0;
        end else begin
            ch0Clk <= divTick; // R7
        end
    end

    // Pair 0/1 source mux enable, low while powered down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pair01MuxEn <= 1'b0;
        end else begin
            pair01MuxEn <= !pd01; // R9
        end
    end

    // Pair 2/3 selected source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pair23Clk <= 1'b0;
        end else begin
            pair23Clk <= pair23Src; // R8
        end
    end

    // Two driver decoders: index 0 is output 1, index 1 is output 2
    drv_cfg_if cfgIf[2] ();
    assign cfgIf[0].format = outCtl1_reg[FMT_HI:FMT_LO]; // R1
    assign cfgIf[0].mode1 = outCtl1_reg[M1_HI:M1_LO];
    assign cfgIf[0].mode2 = outCtl1_reg[M2_HI:M2_LO];
    assign cfgIf[0].chanClk = divTick; // R7
    assign cfgIf[1].format = outCtl2_reg[FMT_HI:FMT_LO]; // R2
    assign cfgIf[1].mode1 = outCtl2_reg[M1_HI:M1_LO];
    assign cfgIf[1].mode2 = outCtl2_reg[M2_HI:M2_LO];
    assign cfgIf[1].chanClk = pair23Src;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_drv
            output_driver_decode u_dec (
                .cfg(cfgIf[gi])
            );
            // Registered pin and setting outputs
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    drvPos[gi] <= 1'b0;
                    drvPosOe[gi] <= 1'b0;
                    drvNeg[gi] <= 1'b0;
                    drvNegOe[gi] <= 1'b0;
                    drvDiffEn[gi] <= 1'b0;
                    drvTailMa[gi*5 +: 5] <= 5'h00;
                    drvLoadOhm[gi*8 +: 8] <= 8'h00;
                end else begin
                    drvPos[gi] <= cfgIf[gi].posOut;
                    drvPosOe[gi] <= cfgIf[gi].posOe;
                    drvNeg[gi] <= cfgIf[gi].negOut;
                    drvNegOe[gi] <= cfgIf[gi].negOe;
                    drvDiffEn[gi] <= cfgIf[gi].diffEn;
                    drvTailMa[gi*5 +: 5] <= cfgIf[gi].tailMa;
                    drvLoadOhm[gi*8 +: 8] <= cfgIf[gi].loadOhm;
                end
            end
        end
    endgenerate
endmodule

// ---- rtl/outcfg_pkg.sv ----
// Constants shared by the output channel configuration block.
// Notes on behaviour
// (R1) Output 1 format bits [6:5], reset 1: off, AC differential, HCSL, LVCMOS.
// (R2) Output 2 format bits [6:5], reset 1, same four-way encoding as output 1.
// (R3) LVCMOS: bits [4:3], reset 2, set positive leg: tristate, low, inverted, true.
// (R4) Differential: bits [4:3] give tail 4, 6, 8 mA, or 16 HCSL / 8 mA.
// (R5) Bits [2:1], reset 0: HCSL load off/50/100/200 ohm; LVCMOS negative leg.
// (R6) Pair 0/1 divider field, reset 0x01, divides by value plus one (1..256).
// (R7) One divider instance feeds both channel 0 and channel 1.
// (R8) Output 2 bit [7], reset 1, picks synthesizer 1 or 2 for channels 2/3.
// (R9) Pair 0/1 powerdown stops its source mux and divider; buffer needs format 0.
// (R10) Reserved bits read as zero and ignore writes.
package outcfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PWRDN = 8'h1e;
    localparam logic [7:0] IDX_STATUS = 8'h1f;
    localparam logic [7:0] IDX_OUT1 = 8'h20;
    localparam logic [7:0] IDX_DIV01 = 8'h21;
    localparam logic [7:0] IDX_OUT2 = 8'h22;
    localparam logic [9:0] ADR_PWRDN = {IDX_PWRDN, 2'b00};
    localparam logic [9:0] ADR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [9:0] ADR_OUT1 = {IDX_OUT1, 2'b00};
    localparam logic [9:0] ADR_DIV01 = {IDX_DIV01, 2'b00};
    localparam logic [9:0] ADR_OUT2 = {IDX_OUT2, 2'b00};
    // Field positions
    localparam int SRC_BIT = 7;
    localparam int FMT_HI = 6;
    localparam int FMT_LO = 5;
    localparam int M1_HI = 4;
    localparam int M1_LO = 3;
    localparam int M2_HI = 2;
    localparam int M2_LO = 1;
    localparam int PD01_BIT = 0;
    // Reset values and writable masks
    localparam logic [7:0] RST_OUT1 = 8'h30;
    localparam logic [7:0] RST_OUT2 = 8'hb0;
    localparam logic [7:0] RST_DIV01 = 8'h01;
    localparam logic [7:0] RST_PWRDN = 8'h00;
    localparam logic [7:0] MSK_OUT1 = 8'h7e;
    localparam logic [7:0] MSK_OUT2 = 8'hfe;
    localparam logic [7:0] MSK_DIV01 = 8'hff;
    localparam logic [7:0] MSK_PWRDN = 8'h01;
    // Driver formats
    typedef enum logic [1:0] {
        FMT_OFF = 2'b00,
        FMT_ACDIFF = 2'b01,
        FMT_HCSL = 2'b10,
        FMT_CMOS = 2'b11
    } drv_format_e;
    // Leg states in LVCMOS format
    localparam logic [1:0] LEG_TRI = 2'h0;
    localparam logic [1:0] LEG_LOW = 2'h1;
    localparam logic [1:0] LEG_INV = 2'h2;
    localparam logic [1:0] LEG_TRUE = 2'h3;
    // Tail currents in mA and loads in ohm
    localparam logic [4:0] TAIL_LVDS = 5'h04;
    localparam logic [4:0] TAIL_CML = 5'h06;
    localparam logic [4:0] TAIL_PECL = 5'h08;
    localparam logic [4:0] TAIL_HCSL = 5'h10;
    localparam logic [7:0] LOAD_50 = 8'h32;
    localparam logic [7:0] LOAD_100 = 8'h64;
    localparam logic [7:0] LOAD_200 = 8'hc8;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- rtl/drv_cfg_if.sv ----
// Interface carrying one output driver's settings and its decoded pin state.
`timescale 1ns/1ns
interface drv_cfg_if;
    import outcfg_pkg::*;
    logic [1:0] format;
    logic [1:0] mode1;
    logic [1:0] mode2;
    logic chanClk;
    logic posOut;
    logic posOe;
    logic negOut;
    logic negOe;
    logic diffEn;
    logic [4:0] tailMa;
    logic [7:0] loadOhm;
    modport ctrl (output format, mode1, mode2, chanClk,
                  input posOut, posOe, negOut, negOe, diffEn, tailMa, loadOhm);
    modport drv (input format, mode1, mode2, chanClk,
                 output posOut, posOe, negOut, negOe, diffEn, tailMa, loadOhm);
endinterface

// ---- rtl/output_driver_decode.sv ----
// Decodes one driver's format and mode fields into pin and analog settings.
`timescale 1ns/1ns
module output_driver_decode
    import outcfg_pkg::*;
(
    // Settings in, pin state out
    drv_cfg_if.drv cfg
);
    // Leg level for an LVCMOS state code
    function automatic logic legLevel(input logic [1:0] st, input logic c);
        legLevel = (st == LEG_TRUE) ? c : ((st == LEG_INV) ? ~c : 1'b0);
    endfunction

    // Format-dependent decode of the mode fields
    always_comb begin
        cfg.posOut = 1'b0;
        cfg.posOe = 1'b0;
        cfg.negOut = 1'b0;
        cfg.negOe = 1'b0;
        cfg.diffEn = 1'b0;
        cfg.tailMa = 5'h00;
        cfg.loadOhm = 8'h00;
        case (cfg.format)
            FMT_CMOS: begin
                cfg.posOut = legLevel(cfg.mode1, cfg.chanClk); // R3
                cfg.posOe = (cfg.mode1 != LEG_TRI); // R3
                cfg.negOut = legLevel(cfg.mode2, cfg.chanClk); // R5
                cfg.negOe = (cfg.mode2 != LEG_TRI); // R5
            end
            FMT_ACDIFF, FMT_HCSL: begin
                cfg.diffEn = 1'b1;
                cfg.posOut = cfg.chanClk;
                cfg.posOe = 1'b1;
                cfg.negOut = ~cfg.chanClk;
                cfg.negOe = 1'b1;
                case (cfg.mode1)
                    2'h0: cfg.tailMa = TAIL_LVDS; // R4
                    2'h1: cfg.tailMa = TAIL_CML; // R4
                    2'h2: cfg.tailMa = TAIL_PECL; // R4
                    default: cfg.tailMa = (cfg.format == FMT_HCSL) ? TAIL_HCSL : TAIL_PECL; // R4
                endcase
                if (cfg.format == FMT_HCSL) begin
                    case (cfg.mode2)
                        2'h1: cfg.loadOhm = LOAD_50; // R5
                        2'h2: cfg.loadOhm = LOAD_100; // R5
                        2'h3: cfg.loadOhm = LOAD_200; // R5
                        default: cfg.loadOhm = 8'h00; // R5
                    endcase
                end
            end
            default: begin
                cfg.diffEn = 1'b0;
            end
        endcase
    end
endmodule

// ---- rtl/pair_divider.sv ----
// Shared output divider: one output pulse per (ratio field + 1) source ticks.
`timescale 1ns/1ns
module pair_divider #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic [DIV_W-1:0] ratioM1,
    // Source and divided output
    input wire logic srcTick,
    output logic divTick
);
    logic [DIV_W-1:0] count_reg;

    // Count source ticks; wrap at the programmed value so a smaller new ratio takes at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (!enable) begin
            count_reg <= '0; // R9
        end else if (srcTick) begin
            if (count_reg >= ratioM1) begin
                count_reg <= '0; // R6
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // Pulse on the tick that closes each period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divTick <= 1'b0;
        end else begin
            divTick <= enable && srcTick && (count_reg >= ratioM1); // R6
        end
    end
endmodule

// ---- sim/output_channel_config_regs_props.sv ----
// Checker for the output channel configuration register bank.
`timescale 1ns/1ns
module output_channel_config_regs_props
    import outcfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // Datapath
    input wire logic ch0Clk,
    input wire logic pair01MuxEn,
    input wire logic [1:0] drvDiffEn,
    input wire logic [9:0] drvTailMa,
    input wire logic [15:0] drvLoadOhm
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Steps of a write and of a powered-down pair
    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence muxOff;
        !pair01MuxEn [*4];
    endsequence

    // Bus handshakes
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    write_answer_a: assert property (wrTaken |-> ##[1:3] bvalid)
        else $error("write response missing");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data missing");
    write_refuse_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while answering");
    // Read data upper bits, decoded driver settings and the powered-down divider
    rdata_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    tail_legal_a: assert property (drvDiffEn[0] |-> drvTailMa[4:0] inside {4, 6, 8, 16})
        else $error("output 1 tail current illegal");
    tail_off_a: assert property (!drvDiffEn[1] |-> drvTailMa[9:5] == 5'h00)
        else $error("output 2 tail current outside differential");
    load_hcsl_a: assert property (drvLoadOhm[7:0] != 8'h00 |-> drvDiffEn[0])
        else $error("output 1 load outside differential");
    pair_off_a: assert property (muxOff |-> !ch0Clk)
        else $error("divided clock while powered down");
endmodule

bind output_channel_config_regs output_channel_config_regs_props u_props (
    .clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .ch0Clk(ch0Clk), .pair01MuxEn(pair01MuxEn),
    .drvDiffEn(drvDiffEn), .drvTailMa(drvTailMa), .drvLoadOhm(drvLoadOhm));

// ---- sim/output_channel_config_regs_tb.sv ----
// Self-checking bench for the output channel configuration register bank.
`timescale 1ns/1ns
module output_channel_config_regs_tb;
    import outcfg_pkg::*;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic synth1In, synth2In, pair01SrcIn, awready, wready, bvalid, arready, rvalid;
    logic ch0Clk, pair01MuxEn, pair23Clk, diff, oe, prevPos, lp, ln;
    logic [7:0] awaddr, araddr, ld8;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp, drvPos, drvPosOe, drvNeg, drvNegOe, drvDiffEn;
    logic [9:0] drvTailMa;
    logic [15:0] drvLoadOhm;
    logic [4:0] tl5;
    int n_mismatch = 0;
    int total_checks = 0;
    int pulses = 0;
    int posCnt = 0;
    int tailTab[4] = '{4, 6, 8, 8};
    int loadTab[4] = '{0, 50, 100, 200};
    int divTab[3] = '{0, 2, 255};

    output_channel_config_regs u_dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .synth1In(synth1In), .synth2In(synth2In), .pair01SrcIn(pair01SrcIn),
        .ch0Clk(ch0Clk), .pair01MuxEn(pair01MuxEn), .pair23Clk(pair23Clk),
        .drvPos(drvPos), .drvPosOe(drvPosOe), .drvNeg(drvNeg), .drvNegOe(drvNegOe),
        .drvDiffEn(drvDiffEn), .drvTailMa(drvTailMa), .drvLoadOhm(drvLoadOhm));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Counts divided pulses and rising edges of the output 1 positive leg
    always @(posedge clk) begin
        if (ch0Clk === 1'b1) pulses++;
        if (drvPos[0] === 1'b1 && prevPos !== 1'b1) posCnt++;
        prevPos = drvPos[0];
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Bus write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int t;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            t++;
        end while (bvalid !== 1'b1 && t < 50);
        rsp = bresp;
        bready <= 1'b0;
        if (t >= 50) chk("write answer", 32'h1, 32'(bvalid));
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, 4'h1);
    endtask

    // Bus read
    task automatic axr(input logic [7:0] a);
        int t;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            t++;
        end while (rvalid !== 1'b1 && t < 50);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (t >= 50) chk("read answer", 32'h1, 32'(rvalid));
    endtask

    task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(w, e, rd);
    endtask

    // Source edges spaced for the input synchronisers
    task automatic srcEdges(input int n);
        repeat (n) begin
            pair01SrcIn <= 1'b1;
            waitc(4);
            pair01SrcIn <= 1'b0;
            waitc(4);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #(40 * 30000);
        n_mismatch++;
        $display("watchdog expired");
        results();
    end

    // Test sequence
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {synth1In, synth2In, pair01SrcIn} = 3'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdc("out1 reset", ADR_OUT1[7:0], 32'h30);
        rdc("div reset", ADR_DIV01[7:0], 32'h01);
        rdc("out2 reset", ADR_OUT2[7:0], 32'hb0);
        rdc("pwrdn reset", ADR_PWRDN[7:0], 32'h00);
        $display("test reset values done");
        wr(ADR_OUT1[7:0], 32'hffffffff);
        rdc("out1 reserved", ADR_OUT1[7:0], 32'h7e);
        wr(ADR_OUT2[7:0], 32'hffffffff);
        rdc("out2 reserved", ADR_OUT2[7:0], 32'hfe);
        axw(ADR_OUT1[7:0], 32'h00, 4'h0);
        rdc("out1 no strobe", ADR_OUT1[7:0], 32'h7e);
        axw(8'h00, 32'h01, 4'h1);
        chk("unmapped wr resp", RESP_SLVERR, rsp);
        axr(8'h00);
        chk("unmapped rd resp", RESP_SLVERR, rsp);
        chk("unmapped rd data", 32'h0, rd);
        $display("test access done");
        for (int f = 0; f < 4; f++) begin
            for (int m = 0; m < 4; m++) begin
                wr(ADR_OUT1[7:0], 32'(f * 32 + m * 10));
                wr(ADR_OUT2[7:0], 32'(f * 32 + m * 10));
                waitc(6);
                diff = (f == 1 || f == 2);
                tl5 = !diff ? 5'h00 : (f == 2 && m == 3) ? 5'h10 : 5'(tailTab[m]);
                ld8 = (f == 2) ? 8'(loadTab[m]) : 8'h00;
                oe = diff || (f == 3 && m != 0);
                lp = (f == 3 && m == 2);
                ln = diff || lp;
                chk("diffEn", 32'({diff, diff}), drvDiffEn);
                chk("tail", 32'({tl5, tl5}), drvTailMa);
                chk("load", 32'({ld8, ld8}), drvLoadOhm);
                chk("posOe", 32'({oe, oe}), drvPosOe);
                chk("negOe", 32'({oe, oe}), drvNegOe);
                chk("legs", 32'({lp, lp, ln, ln}), {drvPos, drvNeg});
            end
        end
        $display("test driver decode done");
        synth1In <= 1'b1;
        wr(ADR_OUT2[7:0], 32'h30);
        waitc(6);
        chk("source synth1", 32'h1, pair23Clk);
        wr(ADR_OUT2[7:0], 32'hb0);
        waitc(6);
        chk("source synth2", 32'h0, pair23Clk);
        $display("test source select done");
        foreach (divTab[i]) begin
            wr(ADR_PWRDN[7:0], 32'h1);
            wr(ADR_DIV01[7:0], 32'(divTab[i]));
            rdc("div value", ADR_DIV01[7:0], 32'(divTab[i]));
            wr(ADR_PWRDN[7:0], 32'h0);
            waitc(6);
            pulses = 0;
            posCnt = 0;
            srcEdges(2 * (divTab[i] + 1));
            waitc(8);
            chk("ch0 pulses", 32'h2, 32'(pulses));
            chk("out1 pulses", 32'h2, 32'(posCnt));
        end
        $display("test divider done");
        wr(ADR_DIV01[7:0], 32'h0);
        wr(ADR_PWRDN[7:0], 32'h1);
        waitc(6);
        chk("mux off", 32'h0, pair01MuxEn);
        pulses = 0;
        srcEdges(4);
        chk("pulses off", 32'h0, 32'(pulses));
        wr(ADR_PWRDN[7:0], 32'h0);
        waitc(6);
        rdc("status", ADR_STATUS[7:0], 32'h1);
        $display("test powerdown done");
        results();
    end
endmodule
